// ==== rtl/hscq_pkg.sv ====
// hscq_pkg: constants, register map and types of the fast input counter block
package hscq_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int HQ_NCH = 4;
  localparam int HQ_CFG_W = 11;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] HQ_OFF_CFG0 = 8'h00;
  localparam logic [7:0] HQ_OFF_CPR0 = 8'h10;
  localparam logic [7:0] HQ_OFF_ACC0 = 8'h20;
  localparam logic [7:0] HQ_OFF_PRESET0 = 8'h30;
  localparam logic [7:0] HQ_OFF_PRESET1 = 8'h34;
  localparam logic [7:0] HQ_OFF_LADDER = 8'h38;
  localparam logic [7:0] HQ_OFF_OUTCFG = 8'h3c;
  localparam logic [7:0] HQ_OFF_STATUS = 8'h40;

  ////////////////////////////////////////////////////////////////////////////////
  // channel config and output config fields
  localparam int HQ_CFG_MODE_LSB = 0;
  localparam int HQ_CFG_EDGE_BIT = 3;
  localparam int HQ_CFG_SUB_LSB = 4;
  localparam int HQ_CFG_MARK_LSB = 6;
  localparam int HQ_CFG_DIR_BIT = 10;
  localparam int HQ_OCFG_PLAIN_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [HQ_CFG_W-1:0] HQ_CFG_RST = 11'h000;
  localparam logic [31:0] HQ_CPR_RST = 32'h0000_0000;
  localparam logic [31:0] HQ_PRESET_RST = 32'h0000_0000;
  localparam logic [5:0] HQ_OCFG_RST = 6'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int HQ_CLK_NS = 10;
  localparam int HQ_TICK_NS = 1000;
  localparam int HQ_TICK_CYC = HQ_TICK_NS / HQ_CLK_NS;
  localparam int HQ_MIN_EDGE_US = 100;
  localparam int HQ_RST_LAT_US = 100;
  localparam int HQ_MARK_SAMPLE_US = 50;
  localparam int unsigned HQ_US_PER_S = 1000000;
  localparam int unsigned HQ_WIN0_US = 10000;
  localparam int unsigned HQ_WIN1_US = 100000;
  localparam int unsigned HQ_WIN2_US = 500000;
  localparam int unsigned HQ_WIN3_US = 1000000;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {HQ_OFF, HQ_FREQ, HQ_TOT, HQ_PULSE, HQ_QUAD, HQ_TOTRST, HQ_MARKER} hq_mode_e;
  typedef enum logic [1:0] {HQ_OUT_PLAIN, HQ_OUT_PWM, HQ_OUT_CMP} hq_osel_e;

  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic armed;
    logic [31:0] acc;
    logic [31:0] stamp;
    logic [31:0] wcnt;
    logic [31:0] ecnt;
  } hq_ch_s;

endpackage

// ==== rtl/hscq_top.sv ====
// hscq_top: four fast input channels with frequency, totalize, pulse and quadrature modes
//
// What this block does
// RULE1: shared free-running 1 us time base
// RULE2: source keeps edges at least 100 us apart
// RULE3: frequency in hertz over four window choices
// RULE4: totalize counts rising or falling edges only
// RULE5: totalizer wraps to zero at cpr minus one
// RULE6: ladder clear bits hold totalizer at zero
// RULE7: channel 3/4 edge resets totalizer 1/2
// RULE8: hardware reset acts within 100 us
// RULE9: compare output high when accumulator reaches preset
// RULE10: preset changeable live; zero keeps output low
// RULE11: each function output: plain, pwm or compare
// RULE12: pulse width high or low in ticks
// RULE13: period measured from rising or falling edge
// RULE14: quadrature uses channel pairs 1/2 and 3/4
// RULE15: quadrature counts all four edges per cycle
// RULE16: direction setting chooses up or down
// RULE17: quadrature wraps at cpr, underflows to cpr-1
// RULE18: ladder bits clear or set quadrature counters
// RULE19: channel 3 marker only beside quadrature pair
// RULE20: async marker edge zeroes accumulator
// RULE21: sync marker needs phase edge and marker level
// RULE22: sync marker loads zero or cpr-1 by direction
// RULE23: marker sampled with the quadrature edge
// RULE24: four 32-bit accumulators, two 32-bit presets
// RULE25: accumulators wrap naturally without cpr
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module hscq_top
  import hscq_pkg::*;
#(
  parameter int unsigned FREQ_WIN0_US = HQ_WIN0_US,
  parameter int unsigned FREQ_WIN1_US = HQ_WIN1_US,
  parameter int unsigned FREQ_WIN2_US = HQ_WIN2_US,
  parameter int unsigned FREQ_WIN3_US = HQ_WIN3_US
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // fast inputs and pwm sources
  input wire logic [HQ_NCH-1:0] fast_input_i,
  input wire logic pwm_a_i,
  input wire logic pwm_b_i,
  // function outputs
  output logic function_output_a_o,
  output logic function_output_b_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // derived constants
  localparam int DIV_W = $clog2(HQ_TICK_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HQ_TICK_CYC - 1);
  localparam int unsigned MUL0 = HQ_US_PER_S / FREQ_WIN0_US;
  localparam int unsigned MUL1 = HQ_US_PER_S / FREQ_WIN1_US;
  localparam int unsigned MUL2 = HQ_US_PER_S / FREQ_WIN2_US;
  localparam int unsigned MUL3 = HQ_US_PER_S / FREQ_WIN3_US;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [31:0] now;
    hq_ch_s [HQ_NCH-1:0] ch;
    logic [HQ_NCH-1:0][HQ_CFG_W-1:0] cfg;
    logic [HQ_NCH-1:0][31:0] counts_per_revolution;
    logic [1:0][31:0] preset;
    logic [HQ_NCH-1:0] ladder;
    logic [5:0] ocfg;
    logic [1:0] hit;
    logic [1:0] fout;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } hq_state_s;

  hq_state_s state_r;
  hq_state_s state_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] cpr_top(input logic [31:0] counts_per_revolution);
    // zero cpr means full range, so the top is all ones
    cpr_top = (counts_per_revolution == 32'h0) ? 32'hffff_ffff : counts_per_revolution - 32'h1;
  endfunction

  function automatic logic [31:0] inc_wrap(input logic [31:0] acc, input logic [31:0] counts_per_revolution);
    inc_wrap = (counts_per_revolution != 32'h0 && acc >= counts_per_revolution - 32'h1) ? 32'h0 : acc + 32'h1;
  endfunction

  function automatic logic [31:0] dec_wrap(input logic [31:0] acc, input logic [31:0] counts_per_revolution);
    dec_wrap = (acc == 32'h0) ? cpr_top(counts_per_revolution) : acc - 32'h1;
  endfunction

  function automatic logic [31:0] win_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: win_last = 32'(FREQ_WIN0_US - 1);
      2'h1: win_last = 32'(FREQ_WIN1_US - 1);
      2'h2: win_last = 32'(FREQ_WIN2_US - 1);
      2'h3: win_last = 32'(FREQ_WIN3_US - 1);
    endcase
  endfunction

  function automatic logic [31:0] freq_scale(input logic [31:0] cnt, input logic [1:0] sel);
    unique case (sel)
      2'h0: freq_scale = 32'(cnt * MUL0);
      2'h1: freq_scale = 32'(cnt * MUL1);
      2'h2: freq_scale = 32'(cnt * MUL2);
      2'h3: freq_scale = 32'(cnt * MUL3);
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr[1:0] == 2'h0) && (addr <= HQ_OFF_STATUS);
  endfunction

  function automatic hq_mode_e mode_of(input logic [HQ_CFG_W-1:0] cfg);
    mode_of = hq_mode_e'(cfg[HQ_CFG_MODE_LSB +: 3]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic tick;
    logic [HQ_NCH-1:0] lvl;
    logic [HQ_NCH-1:0] rise;
    logic [HQ_NCH-1:0] fall;
    logic [HQ_NCH-1:0] tedge;
    logic [1:0] sub;
    logic a_lvl;
    logic b_lvl;
    logic up;
    logic dn;
    logic mev;
    logic ph_r;
    logic ph_f;
    logic [3:0] mk;
    logic [31:0] rd;
    tick = 1'b0;
    lvl = '0;
    rise = '0;
    fall = '0;
    tedge = '0;
    sub = 2'h0;
    a_lvl = 1'b0;
    b_lvl = 1'b0;
    up = 1'b0;
    dn = 1'b0;
    mev = 1'b0;
    ph_r = 1'b0;
    ph_f = 1'b0;
    mk = 4'h0;
    rd = 32'h0;
    state_nxt = state_r;

    // one microsecond tick, shared by every channel [RULE1]
    if (state_r.div == DIV_LAST)
    begin
      state_nxt.div = '0;
      tick = 1'b1;
      state_nxt.now = state_r.now + 32'h1;
    end
    else
    begin
      state_nxt.div = state_r.div + DIV_W'(1);
    end

    // three-stage sync; a level counts once stages two and three agree
    for (int i = 0; i < HQ_NCH; i++)
    begin
      state_nxt.ch[i].sync = {state_r.ch[i].sync[1:0], fast_input_i[i]};
      lvl[i] = (state_r.ch[i].sync[1] == state_r.ch[i].sync[2]) ? state_r.ch[i].sync[2] : state_r.ch[i].lvl;
      state_nxt.ch[i].lvl = lvl[i];
      rise[i] = lvl[i] & ~state_r.ch[i].lvl;
      fall[i] = ~lvl[i] & state_r.ch[i].lvl;
      tedge[i] = state_r.cfg[i][HQ_CFG_EDGE_BIT] ? fall[i] : rise[i];
    end

    // per channel measurement
    for (int i = 0; i < HQ_NCH; i++)
    begin
      sub = state_r.cfg[i][HQ_CFG_SUB_LSB +: 2];
      unique case (mode_of(state_r.cfg[i]))
        HQ_FREQ:
        begin
          // rising edges over a whole window, scaled to hertz [RULE3]
          if (tick && state_r.ch[i].wcnt >= win_last(sub))
          begin
            state_nxt.ch[i].acc = freq_scale(state_r.ch[i].ecnt + 32'(rise[i]), sub);
            state_nxt.ch[i].ecnt = 32'h0;
            state_nxt.ch[i].wcnt = 32'h0;
          end
          else
          begin
            state_nxt.ch[i].ecnt = state_r.ch[i].ecnt + 32'(rise[i]);
            if (tick)
            begin
              state_nxt.ch[i].wcnt = state_r.ch[i].wcnt + 32'h1;
            end
          end
        end
        HQ_TOT:
        begin
          if (tedge[i]) // [RULE4]
          begin
            state_nxt.ch[i].acc = inc_wrap(state_r.ch[i].acc, state_r.counts_per_revolution[i]); // [RULE5] [RULE25]
          end
        end
        HQ_PULSE:
        begin
          // widths and periods count the shared tick; first result waits for an armed start
          unique case (sub)
            2'h0, 2'h1:
            begin
              if (sub == 2'h0 ? rise[i] : fall[i])
              begin
                state_nxt.ch[i].stamp = state_r.now;
                state_nxt.ch[i].armed = 1'b1;
              end
              else if ((sub == 2'h0 ? fall[i] : rise[i]) && state_r.ch[i].armed)
              begin
                state_nxt.ch[i].acc = state_r.now - state_r.ch[i].stamp; // [RULE12]
              end
            end
            2'h2, 2'h3:
            begin
              if (sub == 2'h2 ? rise[i] : fall[i])
              begin
                if (state_r.ch[i].armed)
                begin
                  state_nxt.ch[i].acc = state_r.now - state_r.ch[i].stamp; // [RULE13]
                end
                state_nxt.ch[i].stamp = state_r.now;
                state_nxt.ch[i].armed = 1'b1;
              end
            end
          endcase
        end
        default:
        begin
          state_nxt.ch[i].armed = 1'b0;
        end
      endcase

      // ladder clear is level sensitive [RULE6]
      if (mode_of(state_r.cfg[i]) == HQ_TOT && state_r.ladder[i])
      begin
        state_nxt.ch[i].acc = 32'h0;
      end
    end

    // hardware reset from channel 3/4, only onto a configured totalizer; acts next edge [RULE7] [RULE8]
    for (int i = 0; i < 2; i++)
    begin
      if (mode_of(state_r.cfg[i]) == HQ_TOT && mode_of(state_r.cfg[i + 2]) == HQ_TOTRST && tedge[i + 2])
      begin
        state_nxt.ch[i].acc = 32'h0;
      end
    end

    // quadrature on pairs 1/2 and 3/4 only [RULE14]
    for (int q = 0; q < 2; q++)
    begin
      if (mode_of(state_r.cfg[2 * q]) == HQ_QUAD)
      begin
        a_lvl = lvl[2 * q];
        b_lvl = lvl[2 * q + 1];
        up = (rise[2 * q] & ~b_lvl) | (rise[2 * q + 1] & a_lvl) | (fall[2 * q] & b_lvl)
          | (fall[2 * q + 1] & ~a_lvl); // [RULE15]
        dn = (rise[2 * q] & b_lvl) | (rise[2 * q + 1] & ~a_lvl) | (fall[2 * q] & ~b_lvl)
          | (fall[2 * q + 1] & a_lvl);
        if (state_r.cfg[2 * q][HQ_CFG_DIR_BIT]) // [RULE16]
        begin
          {up, dn} = {dn, up};
        end
        // both phases moving in one cycle is a lost step, so no count
        if (up && !dn)
        begin
          state_nxt.ch[2 * q].acc = inc_wrap(state_r.ch[2 * q].acc, state_r.counts_per_revolution[2 * q]); // [RULE17]
        end
        else if (dn && !up)
        begin
          state_nxt.ch[2 * q].acc = dec_wrap(state_r.ch[2 * q].acc, state_r.counts_per_revolution[2 * q]); // [RULE17]
        end

        // marker only beside the first pair [RULE19]
        if (q == 0 && mode_of(state_r.cfg[2]) == HQ_MARKER)
        begin
          mk = state_r.cfg[2][HQ_CFG_MARK_LSB +: 4];
          if (!mk[3])
          begin
            unique case (mk[1:0])
              2'h0: mev = rise[2];
              2'h1: mev = fall[2];
              default: mev = rise[2] | fall[2];
            endcase
            if (mev)
            begin
              state_nxt.ch[0].acc = 32'h0; // [RULE20]
            end
          end
          else
          begin
            ph_r = mk[1] ? rise[1] : rise[0];
            ph_f = mk[1] ? fall[1] : fall[0];
            // marker level taken in the same cycle as the phase edge [RULE23]
            if ((ph_r | ph_f) && (lvl[2] != mk[2])) // [RULE21]
            begin
              state_nxt.ch[0].acc = (ph_r ^ mk[0]) ? 32'h0 : cpr_top(state_r.counts_per_revolution[0]); // [RULE22]
            end
          end
        end

        // ladder clear beats ladder set, both beat counting [RULE18]
        if (state_r.ladder[2 * q])
        begin
          state_nxt.ch[2 * q].acc = 32'h0;
        end
        else if (state_r.ladder[2 * q + 1])
        begin
          state_nxt.ch[2 * q].acc = cpr_top(state_r.counts_per_revolution[2 * q]);
        end
      end
    end

    // compare and function outputs [RULE11]
    for (int j = 0; j < 2; j++)
    begin
      state_nxt.hit[j] = mode_of(state_r.cfg[j]) == HQ_TOT && state_r.preset[j] != 32'h0
        && state_nxt.ch[j].acc >= state_r.preset[j]; // [RULE9] [RULE10]
      unique case (hq_osel_e'(state_r.ocfg[2 * j +: 2]))
        HQ_OUT_PLAIN: state_nxt.fout[j] = state_r.ocfg[HQ_OCFG_PLAIN_LSB + j];
        HQ_OUT_PWM: state_nxt.fout[j] = (j == 0) ? pwm_a_i : pwm_b_i;
        HQ_OUT_CMP: state_nxt.fout[j] = state_nxt.hit[j];
        default: state_nxt.fout[j] = 1'b0;
      endcase
    end

    // apb: one wait state, answer registered
    state_nxt.pready = 1'b0;
    state_nxt.pslverr = 1'b0;
    if (psel_i && penable_i && !state_r.pready)
    begin
      unique case (paddr_i[7:4])
        4'h0: rd = 32'(state_r.cfg[paddr_i[3:2]]);
        4'h1: rd = state_r.counts_per_revolution[paddr_i[3:2]];
        4'h2: rd = state_r.ch[paddr_i[3:2]].acc; // [RULE24]
        4'h3:
        begin
          unique case (paddr_i[3:2])
            2'h0: rd = state_r.preset[0];
            2'h1: rd = state_r.preset[1];
            2'h2: rd = 32'(state_r.ladder);
            2'h3: rd = 32'(state_r.ocfg);
          endcase
        end
        4'h4: rd = 32'({state_r.fout, state_r.hit, lvl});
        default: rd = 32'h0;
      endcase
      state_nxt.pready = 1'b1;
      state_nxt.pslverr = !reg_mapped(paddr_i);
      // read data stands until the next read answer, so writes leave it alone
      if (!pwrite_i)
      begin
        state_nxt.prdata = reg_mapped(paddr_i) ? rd : 32'h0;
      end
    end
    // writes land on the edge that completes the access; presets may change live [RULE10]
    if (psel_i && penable_i && state_r.pready && pwrite_i && reg_mapped(paddr_i))
    begin
      unique case (paddr_i[7:4])
        4'h0: state_nxt.cfg[paddr_i[3:2]] = pwdata_i[HQ_CFG_W-1:0];
        4'h1: state_nxt.counts_per_revolution[paddr_i[3:2]] = pwdata_i;
        4'h3:
        begin
          unique case (paddr_i[3:2])
            2'h0: state_nxt.preset[0] = pwdata_i;
            2'h1: state_nxt.preset[1] = pwdata_i;
            2'h2: state_nxt.ladder = pwdata_i[HQ_NCH-1:0];
            2'h3: state_nxt.ocfg = pwdata_i[5:0];
          endcase
        end
        default:
        begin
          // accumulators and status are read only
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= '0;
      for (int i = 0; i < HQ_NCH; i++)
      begin
        state_r.cfg[i] <= HQ_CFG_RST;
        state_r.counts_per_revolution[i] <= HQ_CPR_RST;
      end
      state_r.preset[0] <= HQ_PRESET_RST;
      state_r.preset[1] <= HQ_PRESET_RST;
      state_r.ocfg <= HQ_OCFG_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign prdata_o = state_r.prdata;
  assign pready_o = state_r.pready;
  assign pslverr_o = state_r.pslverr;
  assign function_output_a_o = state_r.fout[0];
  assign function_output_b_o = state_r.fout[1];

endmodule // hscq_top

// ==== bench/hscq_src_model.sv ====
// hscq_src_model: pulse source and quadrature encoder on the fast inputs
`timescale 1ns/100ps
module hscq_src_model
  import hscq_pkg::*;
#(
  parameter int GAP_CYC = HQ_MIN_EDGE_US * HQ_TICK_CYC
)
(
  // clock
  input wire logic clk_i,
  // source pins, bit 0 is channel 1
  output logic [HQ_NCH-1:0] pins_o
);
  logic [1:0] ph;
  initial
  begin
    pins_o = '0;
    ph = 2'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // new level right after an edge, then held at least the minimum gap
  task automatic drive(input logic [HQ_NCH-1:0] v, input int hold);
    pins_o <= v;
    repeat ((hold > GAP_CYC) ? hold : GAP_CYC) @(posedge clk_i);
  endtask
  task automatic pulse(input int ch, input int hold);
    drive(pins_o | (4'h1 << ch), hold);
    drive(pins_o & ~(4'h1 << ch), hold);
  endtask
  // one encoder step on channels 1/2; ph counts up with channel 1 leading
  task automatic quad(input logic up);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    drive({pins_o[3:2], ph[1], ph[1] ^ ph[0]}, GAP_CYC);
  endtask
endmodule // hscq_src_model

// ==== bench/hscq_top_chk.sv ====
// hscq_top_chk: port-level assertions for the fast input counter block
`timescale 1ns/100ps
module hscq_top_chk
  import hscq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pwm sources and function outputs
  input wire logic pwm_a_i,
  input wire logic pwm_b_i,
  input wire logic function_output_a_o,
  input wire logic function_output_b_o
);
  typedef struct packed {
    logic [5:0] ocfg;
    logic [31:0] pre;
  } hq_chk_s;
  hq_chk_s st_r;
  hq_chk_s st_nxt;
  logic wr_ok;
  logic bad;
  assign wr_ok = psel_i && penable_i && pready_o && pwrite_i;
  assign bad = (paddr_i > HQ_OFF_STATUS) || (paddr_i[1:0] != 2'h0);
  // shadow of output select and first preset, taken from the bus
  always_comb
  begin
    st_nxt = st_r;
    if (wr_ok && paddr_i == HQ_OFF_OUTCFG)
      st_nxt.ocfg = pwdata_i[5:0];
    if (wr_ok && paddr_i == HQ_OFF_PRESET0)
      st_nxt.pre = pwdata_i;
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_answer;
    pready_o ##1 !pready_o;
  endsequence
  // outputs are registered: judge them only once settings have settled
  sequence s_quiet;
    ($stable(st_r) && $stable(pwm_a_i) && $stable(pwm_b_i))[*3];
  endsequence
  a_ready_wait: assert property (s_access |=> s_answer)
    else $error("ready not one cycle after access");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access");
  a_err_unmapped: assert property (pready_o && bad |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready_o && !bad |-> !pslverr_o)
    else $error("mapped access refused");
  a_rdata_hold: assert property ($changed(prdata_o) |-> pready_o && !pwrite_i)
    else $error("read data changed outside read answer");
  a_plain_a: assert property (s_quiet ##0 st_r.ocfg[1:0] == 2'h0 |-> function_output_a_o == st_r.ocfg[4])
    else $error("output a not plain level");
  a_plain_b: assert property (s_quiet ##0 st_r.ocfg[3:2] == 2'h0 |-> function_output_b_o == st_r.ocfg[5])
    else $error("output b not plain level");
  a_pwm_route: assert property (s_quiet ##0 st_r.ocfg[1:0] == 2'h1 |-> function_output_a_o == pwm_a_i)
    else $error("output a not pwm");
  a_low_b: assert property (s_quiet ##0 st_r.ocfg[3:2] == 2'h3 |-> !function_output_b_o)
    else $error("output b not low");
  a_preset_zero: assert property (s_quiet ##0 st_r.ocfg[1:0] == 2'h2 && st_r.pre == 32'h0 |-> !function_output_a_o)
    else $error("compare output high with zero preset");
endmodule // hscq_top_chk

bind hscq_top hscq_top_chk i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pwm_a_i(pwm_a_i),
  .pwm_b_i(pwm_b_i), .function_output_a_o(function_output_a_o), .function_output_b_o(function_output_b_o));

// ==== bench/hscq_top_bench.sv ====
// hscq_top_bench: self-checking bench for the fast input counter block
`timescale 1ns/100ps
module hscq_top_bench
  import hscq_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } hq_row_s;
  // edges 10 us apart, not 100 us: keeps the run short, counts stay exact
  localparam int GAP = 1000;
  localparam logic [7:0] CF = HQ_OFF_CFG0;
  localparam logic [7:0] AC = HQ_OFF_ACC0;
  logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, pwm_a_i, pwm_b_i, rerr;
  logic function_output_a_o, function_output_b_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic [HQ_NCH-1:0] fast_input_i;
  int errors, comparisons;
  hq_row_s rows [10] = '{
    '{1'h0, CF, 32'h0, 32'h0, 1'h0},
    '{1'h0, HQ_OFF_CPR0 + 8'hc, 32'h0, 32'h0, 1'h0},
    '{1'h0, HQ_OFF_PRESET1, 32'h0, 32'h0, 1'h0},
    '{1'h1, HQ_OFF_CPR0, 32'h1234_5678, 32'h0, 1'h0},
    '{1'h0, HQ_OFF_CPR0, 32'h0, 32'h1234_5678, 1'h0},
    '{1'h1, AC, 32'hffff_ffff, 32'h0, 1'h0},
    '{1'h0, AC, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h44, 32'h0, 32'h0, 1'h1},
    '{1'h0, 8'h06, 32'h0, 32'h0, 1'h1},
    '{1'h1, 8'h48, 32'h1, 32'h0, 1'h1}};
  hscq_top #(.FREQ_WIN0_US(100), .FREQ_WIN1_US(200), .FREQ_WIN2_US(500), .FREQ_WIN3_US(1000)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .fast_input_i(fast_input_i), .pwm_a_i(pwm_a_i), .pwm_b_i(pwm_b_i),
    .function_output_a_o(function_output_a_o), .function_output_b_o(function_output_b_o));
  hscq_src_model #(.GAP_CYC(GAP)) i_src (.clk_i(clk_i), .pins_o(fast_input_i));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'h1 && n < 20);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    if (n >= 20)
      errors++;
  endtask
  task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] t, input logic [31:0] g);
    comparisons++;
    if ($isunknown(g) || g + t < x || g > x + t)
    begin
      errors++;
      $display("unexpected %s: expected %0d, seen %0d", n, x, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic x, input logic g);
    comparisons++;
    if (g !== x)
    begin
      errors++;
      $display("unexpected %s: expected %b, seen %b", n, x, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] t);
    apb(1'h0, a, 32'h0);
    chk_word("rdata", x, t, rdat);
  endtask
  // write, let the registered outputs settle, then look at both
  task automatic oc(input logic [7:0] a, input logic [31:0] d, input logic xa, input logic xb);
    apb(1'h1, a, d);
    repeat (3) @(posedge clk_i);
    chk_bit("out_a", xa, function_output_a_o);
    chk_bit("out_b", xb, function_output_b_o);
  endtask
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    errors++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_i = 1'h1;
    {psel_i, penable_i, pwrite_i, pwm_a_i, pwm_b_i, paddr_i, pwdata_i} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk_bit("pslverr", rows[i].e, rerr);
      if (!rows[i].w)
        chk_word("prdata", rows[i].x, 32'h0, rdat);
    end
    $display("test registers done");
    apb(1'h1, CF, 32'h2);
    apb(1'h1, HQ_OFF_CPR0, 32'h3);
    apb(1'h1, CF + 8'h4, 32'ha);
    repeat (4) i_src.pulse(0, GAP);
    rc(AC, 32'h1, 32'h0);
    i_src.drive(4'h2, GAP);
    rc(AC + 8'h4, 32'h0, 32'h0);
    i_src.drive(4'h0, GAP);
    rc(AC + 8'h4, 32'h1, 32'h0);
    apb(1'h1, HQ_OFF_LADDER, 32'h1);
    i_src.pulse(0, GAP);
    rc(AC, 32'h0, 32'h0);
    apb(1'h1, HQ_OFF_LADDER, 32'h0);
    i_src.pulse(0, GAP);
    rc(AC, 32'h1, 32'h0);
    $display("test totalize done");
    apb(1'h1, HQ_OFF_CPR0, 32'h0);
    apb(1'h1, HQ_OFF_PRESET0, 32'h2);
    oc(HQ_OFF_OUTCFG, 32'h2, 1'h0, 1'h0);
    i_src.pulse(0, GAP);
    chk_bit("out_a", 1'h1, function_output_a_o);
    oc(HQ_OFF_PRESET0, 32'h5, 1'h0, 1'h0);
    oc(HQ_OFF_PRESET0, 32'h1, 1'h1, 1'h0);
    oc(HQ_OFF_PRESET0, 32'h0, 1'h0, 1'h0);
    pwm_a_i <= 1'h1;
    oc(HQ_OFF_OUTCFG, 32'h21, 1'h1, 1'h1);
    oc(HQ_OFF_OUTCFG, 32'h0c, 1'h0, 1'h0);
    pwm_b_i <= 1'h1;
    oc(HQ_OFF_OUTCFG, 32'h04, 1'h0, 1'h1);
    $display("test outputs done");
    apb(1'h1, CF + 8'h8, 32'h5);
    apb(1'h1, CF + 8'hc, 32'h5);
    for (int c = 0; c < 2; c++)
    begin
      i_src.drive(4'h4 << c, GAP);
      rc(AC + 8'(4 * c), 32'h0, 32'h0);
      i_src.drive(4'h0, GAP);
    end
    for (int c = 1; c < 4; c++)
      apb(1'h1, CF + 8'(4 * c), 32'h0);
    $display("test hardware reset done");
    apb(1'h1, CF, 32'h4);
    apb(1'h1, HQ_OFF_CPR0, 32'h4);
    apb(1'h1, HQ_OFF_LADDER, 32'h1);
    apb(1'h1, HQ_OFF_LADDER, 32'h0);
    rc(AC, 32'h0, 32'h0);
    repeat (5) i_src.quad(1'h1);
    rc(AC, 32'h1, 32'h0);
    repeat (2) i_src.quad(1'h0);
    rc(AC, 32'h3, 32'h0);
    apb(1'h1, CF, 32'h404);
    i_src.quad(1'h1);
    rc(AC, 32'h2, 32'h0);
    apb(1'h1, HQ_OFF_LADDER, 32'h2);
    rc(AC, 32'h3, 32'h0);
    apb(1'h1, HQ_OFF_LADDER, 32'h0);
    $display("test quadrature done");
    apb(1'h1, CF, 32'h4);
    apb(1'h1, CF + 8'h8, 32'h6);
    repeat (2) i_src.quad(1'h1);
    i_src.drive(i_src.pins_o | 4'h4, GAP);
    rc(AC, 32'h0, 32'h0);
    i_src.drive(i_src.pins_o & 4'hb, GAP);
    apb(1'h1, CF + 8'h8, 32'h206);
    i_src.drive(i_src.pins_o | 4'h4, GAP);
    i_src.quad(1'h1);
    rc(AC, 32'h3, 32'h0);
    i_src.quad(1'h0);
    rc(AC, 32'h0, 32'h0);
    i_src.drive(i_src.pins_o & 4'hb, GAP);
    i_src.quad(1'h1);
    rc(AC, 32'h1, 32'h0);
    $display("test marker done");
    apb(1'h1, CF + 8'h8, 32'h0);
    apb(1'h1, CF, 32'h3);
    repeat (2) i_src.pulse(0, 1500);
    rc(AC, 32'd15, 32'h1);
    apb(1'h1, CF, 32'h23);
    repeat (2) i_src.pulse(0, 1500);
    rc(AC, 32'd30, 32'h1);
    apb(1'h1, CF, 32'h1);
    repeat (10) i_src.pulse(0, GAP);
    rc(AC, 32'd50000, 32'd10000);
    $display("test timing done");
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    chk_bit("out_b", 1'h0, function_output_b_o);
    rst_i <= 1'h0;
    rc(CF, 32'h0, 32'h0);
    $display("test reset done");
    finish_test();
  end
endmodule // hscq_top_bench
